// File: pkg/exarb_pkg.sv
package exarb_pkg;
    // --------------------------------------------------------------------
    // register map (byte addresses on the avalon bus)
    // --------------------------------------------------------------------
    localparam logic [15:0] PENDING_FLAGS_LOW_ADDR  = 16'hfe04;
    localparam logic [15:0] CONTROL_ADDR            = 16'hfe10;
    localparam logic [15:0] STATUS_ADDR             = 16'hfe14;
    localparam logic [15:0] SOURCE_ENABLE_ADDR      = 16'hfe18;
    localparam logic [7:0]  PENDING_FLAGS_LOW_RESET = 8'h00;
    localparam logic [31:0] SOURCE_ENABLE_RESET     = 32'h0000_0000;
    localparam int          PFL_FIRST_BIT           = 2;
    localparam int          PFL_LEVELS              = 6;
    localparam int          NUM_LEVELS              = 24;
    localparam int          CTRL_MASK_BIT           = 0;
    // --------------------------------------------------------------------
    // vectors: level n uses the pair starting at VECTOR_SOFTWARE - 2*n
    // --------------------------------------------------------------------
    localparam logic [15:0] VECTOR_RESET            = 16'hfffe;
    localparam logic [15:0] VECTOR_SOFTWARE         = 16'hfffc;
    localparam logic [4:0]  LEVEL_SOFTWARE          = 5'h00;

    typedef enum logic [2:0] {
        EXARB_RUN    = 3'b000,
        EXARB_STACK  = 3'b001,
        EXARB_VECTOR = 3'b010,
        EXARB_SERVE  = 3'b011,
        EXARB_RETURN = 3'b100
    } exarb_state_t;

    typedef struct packed {
        logic        valid;
        logic        software;
        logic [4:0]  level;
        logic [15:0] vector;
    } exarb_grant_t;

    typedef struct packed {
        logic [15:0] address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } exarb_bus_req_t;
endpackage : exarb_pkg

// File: core/exarb_priority.sv
`timescale 1ns/1ns
`default_nettype none
module exarb_priority
    import exarb_pkg::*;
#(
    parameter int LEVELS = NUM_LEVELS
) (
    input  wire logic [LEVELS:1] candidates,
    output logic                 found,
    output logic [4:0]           level
);
    if (LEVELS < 1 || LEVELS > 31) begin : g_levels_check
        $error("exarb_priority: LEVELS out of range");
    end

    // lowest level number wins
    always_comb begin
        found = 1'b0;
        level = 5'h00;
        for (int i = LEVELS; i >= 1; i--) begin
            if (candidates[i]) begin
                found = 1'b1;
                level = 5'(i);
            end
        end
    end
endmodule : exarb_priority
`default_nettype wire

// File: core/exception_arbitration_unit.sv
// Overview of operation
// - handles maskable and software interrupts, reset, and break as flow changes
// - entry stacks registers, then sets the global mask
// - return instruction unstacks registers and normal execution resumes
// - requests latched; arbitration at entry yields a vector select constant
// - latched request follows its source line every cycle, cleared by reset or when the line drops
// - hardware requests wait for the current instruction to finish
// - at boundary start only if mask clear and source enabled
// - highest priority enabled pending request is serviced first
// - request pending at return is serviced before next main instruction
// - upper index byte is never pushed on interrupt entry
// - software interrupt always taken regardless of global mask
// - software interrupt stacks pc, hardware interrupt stacks pc minus one
// - fixed levels: reset and software at 0, peripherals at 1 to 24
// - first status register read-only, reset zero, bits 7:2 show levels 6:1
// - flag reads one while its source requests, else zero
// - bits 1 and 0 read zero, writes ignored
// - global mask gates all sources except the software interrupt and break
// - reset never arbitrated, always highest priority
// - break forces the software interrupt vector
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
module exception_arbitration_unit
    import exarb_pkg::*;
#(
    parameter int LEVELS = NUM_LEVELS
) (
    input  wire logic              core_clk,
    input  wire logic              nrst,
    // avalon-mm slave
    input  wire logic [15:0]       avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    // peripheral request lines, level 1 at bit 1
    input  wire logic [LEVELS:1]   source_request,
    // cpu core side
    input  wire logic              instr_boundary,
    input  wire logic              software_interrupt,
    input  wire logic              break_request,
    input  wire logic              return_from_interrupt,
    input  wire logic              stack_done,
    input  wire logic              unstack_done,
    input  wire logic              mask_clear,
    input  wire logic [15:0]       program_counter,
    output logic                   take_interrupt,
    output logic                   stack_request,
    output logic                   unstack_request,
    output logic                   push_upper_index,
    output logic [15:0]            stacked_pc,
    output logic [15:0]            vector_address,
    output logic [4:0]             vector_level,
    output logic                   vector_valid,
    output logic                   discard_prefetch,
    output logic                   global_mask
);
    if (LEVELS < PFL_LEVELS || LEVELS > 31) begin : g_levels_check
        $error("exception_arbitration_unit: LEVELS out of range");
    end

    // --------------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------------
    function automatic logic [15:0] level_vector(input logic [4:0] lvl);
        // level 0 is the software pair, each further level one pair lower
        level_vector = VECTOR_SOFTWARE - {10'h000, lvl, 1'b0};
    endfunction : level_vector

    // one-hot and below-level masks over the request vector
    function automatic logic [LEVELS:1] level_bit(input logic [4:0] lvl);
        level_bit = '0;
        for (int i = 1; i <= LEVELS; i++) begin
            level_bit[i] = (lvl == 5'(i));
        end
    endfunction : level_bit

    function automatic logic [LEVELS:1] below_level(input logic [4:0] lvl);
        below_level = '0;
        for (int i = 1; i <= LEVELS; i++) begin
            below_level[i] = (5'(i) < lvl);
        end
    endfunction : below_level

    exarb_state_t state;
    exarb_grant_t grant;
    logic [31:0]  source_enable;
    logic [LEVELS:1] live_request;
    logic [LEVELS:1] candidates;
    logic         hw_found;
    logic [4:0]   hw_level;
    logic         after_return;
    logic         bus_access;
    logic [31:0]  next_readdata;
    logic         read_pending;
    exarb_bus_req_t bus_req;

    assign bus_req = '{address: avs_address, read: avs_read, write: avs_write, writedata: avs_writedata};

    // one clock domain, so checks below share one clock and, except a_reset_idle, one reset
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);

    // --------------------------------------------------------------------
    // request latch and arbitration
    // --------------------------------------------------------------------
    // reset is handled by nrst alone and never reaches this arbiter
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            live_request <= '0;
        end else begin
            live_request <= source_request;
        end
    end

    // gating ahead of the arbiter keeps a masked or disabled source from winning a level
    assign candidates = live_request & source_enable[LEVELS:1] & {LEVELS{~global_mask}};

    exarb_priority #(
        .LEVELS (LEVELS)
    ) u_priority (
        .candidates (candidates),
        .found      (hw_found),
        .level      (hw_level)
    );

    // --------------------------------------------------------------------
    // exception sequencer
    // --------------------------------------------------------------------
    // decisions only at instruction boundaries, never mid-instruction
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state        <= EXARB_RUN;
            grant        <= '0;
            stacked_pc   <= 16'h0000;
            after_return <= 1'b0;
        end else begin
            case (state)
                EXARB_RUN: begin
                    after_return <= 1'b0;
                    if (instr_boundary) begin
                        if (software_interrupt || break_request) begin
                            grant      <= '{valid: 1'b1, software: 1'b1, level: LEVEL_SOFTWARE,
                                            vector: VECTOR_SOFTWARE};
                            stacked_pc <= program_counter;
                            state      <= EXARB_STACK;
                        end else if (hw_found) begin
                            grant      <= '{valid: 1'b1, software: 1'b0, level: hw_level,
                                            vector: level_vector(hw_level)};
                            stacked_pc <= program_counter - 16'h0001;
                            state      <= EXARB_STACK;
                        end
                    end
                end
                EXARB_STACK: begin
                    if (stack_done) begin
                        state <= EXARB_VECTOR;
                    end
                end
                EXARB_VECTOR: begin
                    state <= EXARB_SERVE;
                end
                EXARB_SERVE: begin
                    if (return_from_interrupt) begin
                        state <= EXARB_RETURN;
                    end
                end
                EXARB_RETURN: begin
                    if (unstack_done) begin
                        grant        <= '0;
                        after_return <= 1'b1;
                        state        <= EXARB_RUN;
                    end
                end
                default: begin
                    state <= EXARB_RUN;
                end
            endcase
        end
    end

    // global mask: set after stacking, restored clear by return unless core clears it
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            global_mask <= 1'b1;
        end else if (state == EXARB_STACK && stack_done) begin
            global_mask <= 1'b1;
        end else if (mask_clear || (state == EXARB_RETURN && unstack_done)) begin
            global_mask <= 1'b0;
        end
    end

    assign take_interrupt   = (state == EXARB_STACK);
    assign stack_request    = (state == EXARB_STACK);
    assign unstack_request  = (state == EXARB_RETURN);
    assign push_upper_index = 1'b0;
    assign vector_valid     = (state == EXARB_VECTOR);
    assign vector_address   = grant.vector;
    assign vector_level     = grant.level;
    // immediate re-entry after return makes the prefetched opcode redundant
    assign discard_prefetch = after_return && instr_boundary && (hw_found || software_interrupt);

    // --------------------------------------------------------------------
    // register file
    // --------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            source_enable <= SOURCE_ENABLE_RESET;
        end else if (bus_req.write && bus_req.address == SOURCE_ENABLE_ADDR) begin
            for (int b = 0; b < 4; b++) begin
                if (avs_byteenable[b]) begin
                    source_enable[b*8 +: 8] <= bus_req.writedata[b*8 +: 8];
                end
            end
        end
    end

    // pending flags mirror live requests, ignoring enables and mask
    always_comb begin
        next_readdata = 32'h0000_0000;
        case (bus_req.address)
            PENDING_FLAGS_LOW_ADDR: begin
                next_readdata[PFL_FIRST_BIT +: PFL_LEVELS] = live_request[PFL_LEVELS:1];
            end
            CONTROL_ADDR: begin
                next_readdata[CTRL_MASK_BIT] = global_mask;
            end
            STATUS_ADDR: begin
                next_readdata[LEVELS:1] = live_request;
            end
            SOURCE_ENABLE_ADDR: begin
                next_readdata = source_enable;
            end
            default: begin
                next_readdata = 32'h0000_0000;
            end
        endcase
    end

    // reads take one wait cycle; writes complete at once
    assign bus_access      = bus_req.read && !read_pending;
    assign avs_waitrequest = bus_access;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            read_pending <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            read_pending <= bus_access;
            if (bus_access) begin
                avs_readdata <= next_readdata;
            end
        end
    end

    // --------------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------------
    a_swi_unmasked: assert property (@(posedge core_clk) disable iff (!nrst)
        (state == EXARB_RUN && instr_boundary && software_interrupt) |=> (state == EXARB_STACK && grant.software))
        else $error("software interrupt not taken");
    a_mask_blocks: assert property (@(posedge core_clk) disable iff (!nrst)
        (state == EXARB_RUN && global_mask && !software_interrupt && !break_request) |=> state == EXARB_RUN)
        else $error("masked request entered");
    a_no_midinstr: assert property (@(posedge core_clk) disable iff (!nrst)
        (state == EXARB_RUN && !instr_boundary) |=> state == EXARB_RUN)
        else $error("entry without boundary");
    a_mask_after_stack: assert property (@(posedge core_clk) disable iff (!nrst)
        (state == EXARB_STACK && stack_done) |=> (global_mask && state == EXARB_VECTOR))
        else $error("mask not set after stacking");
    a_hw_pc_minus: assert property (@(posedge core_clk) disable iff (!nrst)
        (state == EXARB_RUN && instr_boundary && !software_interrupt && !break_request && hw_found)
        |=> stacked_pc == $past(program_counter) - 16'h0001)
        else $error("hardware stacked pc wrong");
    a_vector_level: assert property (@(posedge core_clk) disable iff (!nrst)
        vector_valid |-> vector_address == VECTOR_SOFTWARE - {10'h000, vector_level, 1'b0})
        else $error("vector mismatch");
    a_grant_holds: assert property (@(posedge core_clk) disable iff (!nrst)
        (state inside {EXARB_STACK, EXARB_VECTOR, EXARB_SERVE}) |=> $stable(grant))
        else $error("latched grant pre-empted");
    a_flags_low_zero: assert property (@(posedge core_clk) disable iff (!nrst)
        (read_pending && $past(bus_req.address) == PENDING_FLAGS_LOW_ADDR) |-> avs_readdata[1:0] == 2'b00)
        else $error("reserved bits nonzero");
    a_no_index_push: assert property (@(posedge core_clk) disable iff (!nrst)
        stack_request |-> !push_upper_index)
        else $error("upper index pushed");

    // --------------------------------------------------------------------
    // sequencing checks
    // --------------------------------------------------------------------
    a_reset_idle: assert property (disable iff (1'b0)
        !nrst |=> (state == EXARB_RUN && global_mask && !stack_request))
        else $error("reset did not idle the sequencer");
    a_disabled_held: assert property (
        (state == EXARB_RUN && instr_boundary && !software_interrupt && !break_request && !hw_found)
        |=> state == EXARB_RUN)
        else $error("entry without enabled request");
    a_lowest_wins: assert property (
        (state == EXARB_RUN && instr_boundary && !software_interrupt && !break_request && hw_found)
        |=> (($past(candidates) & below_level(grant.level)) == '0
             && ($past(candidates) & level_bit(grant.level)) != '0))
        else $error("lower priority request served first");
    a_vector_pulse: assert property (
        vector_valid |=> !vector_valid)
        else $error("vector select held too long");
    a_sw_pc_kept: assert property (
        (state == EXARB_RUN && instr_boundary && (software_interrupt || break_request))
        |=> stacked_pc == $past(program_counter))
        else $error("software stacked pc wrong");
    a_break_vector: assert property (
        (state == EXARB_RUN && instr_boundary && break_request)
        |=> (grant.vector == VECTOR_SOFTWARE && grant.level == LEVEL_SOFTWARE))
        else $error("break not sent to software vector");
    a_stack_waits: assert property (
        (state == EXARB_STACK && !stack_done) |=> (state == EXARB_STACK && stack_request))
        else $error("stacking abandoned");
    a_serve_waits: assert property (
        (state == EXARB_SERVE && !return_from_interrupt) |=> state == EXARB_SERVE)
        else $error("service left without return");
    a_unstack_waits: assert property (
        (state == EXARB_RETURN && !unstack_done) |=> (state == EXARB_RETURN && unstack_request))
        else $error("unstacking abandoned");
    a_return_unmasks: assert property (
        (state == EXARB_RETURN && unstack_done) |=> (state == EXARB_RUN && !global_mask))
        else $error("return did not restore");
    a_reentry_taken: assert property (
        (state == EXARB_RUN && after_return && instr_boundary && hw_found) |=> state == EXARB_STACK)
        else $error("pending request skipped after return");
    a_mask_in_service: assert property (
        (state == EXARB_SERVE && !mask_clear) |=> global_mask == $past(global_mask))
        else $error("mask changed during service");
    a_flags_live: assert property (
        (read_pending && $past(bus_req.address) == PENDING_FLAGS_LOW_ADDR)
        |-> avs_readdata[PFL_FIRST_BIT +: PFL_LEVELS] == $past(live_request[PFL_LEVELS:1]))
        else $error("pending flags differ from requests");
    a_read_one_wait: assert property (
        (avs_read && read_pending) |-> !avs_waitrequest)
        else $error("read held beyond one wait");

    c_hw_entry: cover property (@(posedge core_clk) disable iff (!nrst)
        state == EXARB_RUN ##1 (state == EXARB_STACK && !grant.software));
    c_swi_entry: cover property (@(posedge core_clk) disable iff (!nrst)
        state == EXARB_RUN ##1 (state == EXARB_STACK && grant.software));
    c_reentry: cover property (@(posedge core_clk) disable iff (!nrst) discard_prefetch);
    c_flag_read: cover property (@(posedge core_clk) disable iff (!nrst)
        read_pending && avs_readdata != 32'h0000_0000);
    c_break_entry: cover property (
        state == EXARB_RUN && instr_boundary && break_request && !software_interrupt);
endmodule : exception_arbitration_unit
`default_nettype wire

// File: testbench/exarb_core_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// cpu core stand-in
// ----------------------------------------
module exarb_core_model (
    input  wire logic       core_clk,
    input  wire logic       nrst,
    input  wire logic       stack_request,
    input  wire logic       unstack_request,
    input  wire logic [3:0] slow,
    output logic            stack_done,
    output logic            unstack_done
);
    logic [3:0] wait_cnt;
    // one done pulse per request; slow adds idle cycles to test a lazy core
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            wait_cnt     <= 4'h0;
            stack_done   <= 1'b0;
            unstack_done <= 1'b0;
        end else if ((stack_request && !stack_done) || (unstack_request && !unstack_done)) begin
            wait_cnt     <= (wait_cnt == slow) ? 4'h0 : wait_cnt + 4'h1;
            stack_done   <= stack_request && (wait_cnt == slow);
            unstack_done <= unstack_request && (wait_cnt == slow);
        end else begin
            stack_done   <= 1'b0;
            unstack_done <= 1'b0;
        end
    end
endmodule : exarb_core_model
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb import exarb_pkg::*;;
    logic        core_clk, nrst, avs_read, avs_write, avs_waitrequest, instr_boundary;
    logic        software_interrupt, break_request, return_from_interrupt, stack_done, unstack_done;
    logic        mask_clear, take_interrupt, stack_request, unstack_request, push_upper_index;
    logic        vector_valid, discard_prefetch, global_mask;
    logic [15:0] avs_address, program_counter, stacked_pc, vector_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [24:1] source_request;
    logic [4:0]  vector_level;
    logic [3:0]  slow;
    int          mismatches, tests_run;

    exception_arbitration_unit DUT (
        .core_clk(core_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .source_request(source_request),
        .instr_boundary(instr_boundary), .software_interrupt(software_interrupt),
        .break_request(break_request), .return_from_interrupt(return_from_interrupt),
        .stack_done(stack_done), .unstack_done(unstack_done), .mask_clear(mask_clear),
        .program_counter(program_counter), .take_interrupt(take_interrupt), .stack_request(stack_request),
        .unstack_request(unstack_request), .push_upper_index(push_upper_index), .stacked_pc(stacked_pc),
        .vector_address(vector_address), .vector_level(vector_level), .vector_valid(vector_valid),
        .discard_prefetch(discard_prefetch), .global_mask(global_mask)
    );
    exarb_core_model core (
        .core_clk(core_clk), .nrst(nrst), .stack_request(stack_request), .unstack_request(unstack_request),
        .slow(slow), .stack_done(stack_done), .unstack_done(unstack_done)
    );

    always #2 core_clk = ~core_clk;

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        avs_address   <= a;
        avs_writedata <= wd;
        avs_read      <= !wr;
        avs_write     <= wr;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 16);
        rd = avs_readdata;
        chk("bus answer", 32'h0000_0000, 32'(avs_waitrequest));
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask : bus

    task automatic reg_chk(input string what, input logic [15:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(what, exp, rd);
    endtask : reg_chk

    task automatic boundary(input logic sw, input logic brk, input logic [15:0] pc);
        instr_boundary     <= 1'b1;
        software_interrupt <= sw;
        break_request      <= brk;
        program_counter    <= pc;
        @(posedge core_clk);
        instr_boundary     <= 1'b0;
        software_interrupt <= 1'b0;
        break_request      <= 1'b0;
    endtask : boundary

    task automatic no_take(input string what);
        int hits;
        hits = 0;
        repeat (8) begin
            @(posedge core_clk);
            hits += int'(stack_request !== 1'b0) + int'(take_interrupt !== 1'b0);
        end
        chk(what, 32'h0000_0000, 32'(hits));
    endtask : no_take

    task automatic enter(input logic [4:0] lvl, input logic [15:0] vec, input logic [15:0] pc, input logic pc_on);
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (vector_valid !== 1'b1 && n < 40);
        chk("vector valid", 32'h0000_0001, 32'(vector_valid));
        chk("vector level", 32'(lvl), 32'(vector_level));
        chk("vector address", 32'(vec), 32'(vector_address));
        if (pc_on) chk("stacked pc", 32'(pc), 32'(stacked_pc));
        chk("mask after entry", 32'h0000_0001, 32'(global_mask));
        chk("upper index pushed", 32'h0000_0000, 32'(push_upper_index));
    endtask : enter

    // bnd: offer a boundary in the first cycle back in the main program
    task automatic leave(input logic bnd);
        int n;
        n = 0;
        return_from_interrupt <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (unstack_done !== 1'b1 && n < 40);
        chk("unstack request", 32'h0000_0001, 32'(unstack_request));
        return_from_interrupt <= 1'b0;
        instr_boundary        <= bnd;
        @(posedge core_clk);
        instr_boundary        <= 1'b0;
        chk("discard prefetch", 32'(bnd), 32'(discard_prefetch));
        chk("mask after return", 32'h0000_0000, 32'(global_mask));
    endtask : leave

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        reg_chk("flags reset", PENDING_FLAGS_LOW_ADDR, 32'h0000_0000);
        reg_chk("enable reset", SOURCE_ENABLE_ADDR, 32'h0000_0000);
        reg_chk("unmapped", 16'hfe20, 32'h0000_0000);
        reg_chk("control reset", CONTROL_ADDR, 32'h0000_0001);
        chk("mask reset", 32'h0000_0001, 32'(global_mask));
    endtask : t_reset

    task automatic t_flags;
        source_request <= 24'h00_003f;
        repeat (2) @(posedge core_clk);
        reg_chk("flags six", PENDING_FLAGS_LOW_ADDR, 32'h0000_00fc);
        bus(1'b1, PENDING_FLAGS_LOW_ADDR, 32'h0000_00ff);
        reg_chk("flags after write", PENDING_FLAGS_LOW_ADDR, 32'h0000_00fc);
        source_request <= 24'hff_ffc0;
        repeat (2) @(posedge core_clk);
        reg_chk("flags upper", PENDING_FLAGS_LOW_ADDR, 32'h0000_0000);
        reg_chk("live requests", STATUS_ADDR, 32'h01ff_ff80);
    endtask : t_flags

    task automatic t_masked;
        bus(1'b1, SOURCE_ENABLE_ADDR, 32'h01ff_fffe);
        reg_chk("enable readback", SOURCE_ENABLE_ADDR, 32'h01ff_fffe);
        source_request <= 24'h00_0004;
        repeat (2) @(posedge core_clk);
        boundary(1'b0, 1'b0, 16'h1000);
        no_take("masked boundary");
    endtask : t_masked

    task automatic t_swi;
        slow <= 4'h3;
        boundary(1'b1, 1'b0, 16'h1234);
        enter(5'h00, 16'hfffc, 16'h1234, 1'b1);
        source_request <= 24'h00_0000;
        leave(1'b0);
    endtask : t_swi

    task automatic t_prio;
        slow <= 4'h0;
        source_request <= 24'h00_0012;
        no_take("no boundary");
        boundary(1'b0, 1'b0, 16'h2000);
        source_request <= 24'h00_0013;
        enter(5'h02, 16'hfff8, 16'h1fff, 1'b1);
        source_request <= 24'h00_0010;
        leave(1'b1);
        enter(5'h05, 16'hfff2, 16'h1fff, 1'b1);
        source_request <= 24'h00_0000;
        leave(1'b0);
    endtask : t_prio

    task automatic t_break;
        bus(1'b1, SOURCE_ENABLE_ADDR, 32'h0000_0002);
        source_request <= 24'h00_0008;
        repeat (2) @(posedge core_clk);
        boundary(1'b0, 1'b0, 16'h3000);
        no_take("disabled source");
        boundary(1'b0, 1'b1, 16'h3000);
        enter(5'h00, 16'hfffc, 16'h0000, 1'b0);
        mask_clear <= 1'b1;
        @(posedge core_clk);
        mask_clear <= 1'b0;
        @(posedge core_clk);
        chk("mask cleared", 32'h0000_0000, 32'(global_mask));
        source_request <= 24'h00_0000;
        leave(1'b0);
    endtask : t_break

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : print_verdict

    initial begin
        {core_clk, nrst, avs_read, avs_write, instr_boundary, software_interrupt} = 6'h00;
        {break_request, return_from_interrupt, mask_clear} = 3'h0;
        avs_address = 16'h0000;
        avs_writedata = 32'h0000_0000;
        program_counter = 16'h0000;
        source_request = 24'h00_0000;
        slow = 4'h0;
        mismatches = 0;
        tests_run = 0;
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        t_reset;
        t_flags;
        t_masked;
        t_swi;
        t_prio;
        t_break;
        print_verdict;
    end

    initial begin
        repeat (5000) @(posedge core_clk);
        mismatches++;
        $display("Error watchdog expired");
        print_verdict;
    end
endmodule : tb
`default_nettype wire
